/* File: hdl/thermal_protection_regs.svh */
// Constants of the thermal protection block
//
// Notes on behaviour
// - Die at about 120 C forces shutdown and trip output, whatever throttle modes.
// - Trip output depends on no processor activity and makes no bus traffic.
// - Sensor value is read only through the register read port.
// - Sensor reading is valid only in the normal package power state.
// - Sensor reports offset below maximum junction temperature, never above it.
// - Register read carries overtemp status bit set when a throttled core stays hot for the whole window.
// - Throttling engages at the same point the sensor reports maximum temperature.
// - Two programmable thresholds raise an interrupt when temperature crosses them.
// - Throttled and still hot sets overtemp status (clears on cooling), latches sticky bit, and pulses interrupt.
// - Hot signal asserted at maximum temperature; control circuit active meanwhile.
// - Interrupt configurable on hot signal assertion, deassertion, or both edges.
// - Hot signal is two-way; external assertion engages the control circuit.
// - One package hot signal, driven whenever any core sensor trips.
// - Internal trip, modulation only: only the hot core has clocks modulated.
// - Internal trip with performance throttle: hot core drops to lowest state.
// - External hot, modulation only enabled: the core's clocks are modulated.
// - External hot with performance throttle: lowest state only, force ignored.
// - Modulation gates clocks at fixed 50% duty until cooled, with hysteresis.
// - Performance throttle holds lowest mode while hot, then returns to request.
`ifndef THERMAL_PROTECTION_REGS_SVH
`define THERMAL_PROTECTION_REGS_SVH
`define CLK_NS 25
`define CATA_TEMP 8'h78
`define HYST_DEG 8'h02
`define MOD_HALF_NS 500
`define MOD_HALF_CYC (`MOD_HALF_NS / `CLK_NS)
`define OOS_NS 10000
`define OOS_CYC (`OOS_NS / `CLK_NS)
`define OFFSET_RST 8'h00
`endif

/* File: hdl/thermal_pkg.sv */
// Types shared by the thermal protection block
`default_nettype none
package thermal_pkg;
  // Software configuration held outside in model-specific registers
  typedef struct packed {
    logic tm1_en;
    logic tm2_en;
    logic force_mod;
    logic irq_rise;
    logic irq_fall;
    logic [7:0] thresh0;
    logic [7:0] thresh1;
  } cfg_t;
  // Answer of one sensor register read
  typedef struct packed {
    logic valid;
    logic overtemp_status;
    logic sticky;
    logic [7:0] offset;
  } dts_read_t;
  // Per core state
  typedef struct packed {
    logic valid;
    logic [7:0] offset;
    logic tripped;
    logic [1:0] above;
    logic [9:0] oos_cnt;
    logic overtemp_status;
    logic sticky;
    logic [7:0] mod_cnt;
    logic mod_phase;
  } core_state_t;
endpackage
`default_nettype wire

/* File: hdl/thermal_protection_control.sv */
// Thermal protection control: sensor readout, throttling, hot pin and trip
`default_nettype none
`include "thermal_protection_regs.svh"
module thermal_protection_control import thermal_pkg::*; #(
  parameter int NCORES = 2,
  parameter logic [7:0] TJ_MAX = 8'h64,
  parameter int SW = (NCORES > 1) ? $clog2(NCORES) : 1
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Sensor and power state
  input wire logic [NCORES-1:0][7:0] core_temp,
  input wire logic pkg_normal,
  // Configuration and status clear
  input wire cfg_t cfg,
  input wire logic [NCORES-1:0] sticky_clr,
  // Model-specific register read port
  input wire logic msr_rd,
  input wire logic [SW-1:0] msr_core,
  output logic msr_rvalid,
  output dts_read_t msr_rdata,
  // Hot pin, active low, open drain
  input wire logic hot_signal_bidir_in,
  output logic hot_signal_bidir_out,
  output logic hot_signal_bidir_oe_n,
  // Trip, throttles and interrupts
  output logic catastrophic_trip_n,
  output logic [NCORES-1:0] core_clk_run,
  output logic [NCORES-1:0] core_lfm,
  output logic [NCORES-1:0] thermal_irq
);

  localparam logic [7:0] MOD_HALF = 8'(`MOD_HALF_CYC);
  localparam logic [9:0] OOS_CYC = 10'(`OOS_CYC);

  typedef struct packed {
    logic hot_s1;
    logic hot_s2;
    logic hot_d;
    logic trip;
    logic drive_hot;
    logic [1:0] drive_dly;
    logic [NCORES-1:0] run;
    logic [NCORES-1:0] lowest_frequency_mode;
    logic [NCORES-1:0] irq;
    logic rvalid;
    dts_read_t rdata;
    core_state_t [NCORES-1:0] core;
  } state_t;

  state_t s;
  state_t next_s;
  logic ext_hot;
  logic [NCORES-1:0] tripped_vec;
  // Cores at the catastrophic level, seen by the trip assertion
  logic [NCORES-1:0] cata_vec;

  // ----------------------------------------
  // Pin views
  // ----------------------------------------
  // Our own drive reflects on the pin, so the pin counts as external only while we release it.
  // The synchroniser lags the pin by two edges, so our release is masked for two more cycles;
  // otherwise a stale low level would throttle every core as if an outside agent pulled it.
  // external assertion detect
  assign ext_hot = !s.hot_s2 && !s.drive_hot && !(|s.drive_dly);

  always_comb begin
    for (int i = 0; i < NCORES; i++) begin
      tripped_vec[i] = s.core[i].tripped;
      cata_vec[i] = (core_temp[i] >= `CATA_TEMP);
    end
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    core_state_t c;
    logic tm1_on;
    logic tm2_on;
    logic oos_hit;
    logic [1:0] above_now;
    logic hot_rise;
    logic hot_fall;
    logic hot_irq;
    logic any_trip;
    c = '0;
    tm1_on = 1'b0;
    tm2_on = 1'b0;
    oos_hit = 1'b0;
    above_now = 2'b00;
    hot_rise = 1'b0;
    hot_fall = 1'b0;
    hot_irq = 1'b0;
    any_trip = 1'b0;
    next_s = s;
    // Two flops before the pin is looked at
    next_s.hot_s1 = hot_signal_bidir_in;
    next_s.hot_s2 = s.hot_s1;
    next_s.hot_d = s.hot_s2;
    hot_rise = !s.hot_s2 && s.hot_d;
    hot_fall = s.hot_s2 && !s.hot_d;
    hot_irq = (hot_rise && cfg.irq_rise) || (hot_fall && cfg.irq_fall);
    any_trip = 1'b0;
    for (int i = 0; i < NCORES; i++) begin
      c = s.core[i];
      if (pkg_normal) begin
        c.offset = (core_temp[i] >= TJ_MAX) ? 8'h00 : 8'(TJ_MAX - core_temp[i]);
        c.valid = 1'b1;
        // trip at sensor maximum, hysteresis on release
        if (c.offset == 8'h00) begin
          c.tripped = 1'b1;
        end else if (c.offset >= `HYST_DEG) begin
          c.tripped = 1'b0;
        end
      end else begin
        c.valid = 1'b0;
      end
      // catastrophic level, no gating by mode or power state; only reset clears it
      if (core_temp[i] >= `CATA_TEMP) begin
        next_s.trip = 1'b1;
      end
      any_trip = any_trip || c.tripped;
      // performance throttle on internal or external hot
      tm2_on = cfg.tm2_en && (s.core[i].tripped || ext_hot);
      // modulation; force over pstate only for internal trips
      tm1_on = cfg.tm1_en && ((s.core[i].tripped && (!cfg.tm2_en || (cfg.force_mod && s.core[i].overtemp_status)))
               || (ext_hot && !cfg.tm2_en));
      // throttled and still hot for the whole window
      if (s.core[i].tripped && (cfg.tm1_en || cfg.tm2_en)) begin
        if (s.core[i].oos_cnt < OOS_CYC) begin
          c.oos_cnt = 10'(s.core[i].oos_cnt + 10'h001);
        end
      end else begin
        c.oos_cnt = 10'h000;
      end
      c.overtemp_status = (c.oos_cnt == OOS_CYC);
      oos_hit = c.overtemp_status && !s.core[i].overtemp_status;
      // sticky, a set beats a clear
      c.sticky = (s.core[i].sticky && !sticky_clr[i]) || c.overtemp_status;
      if (tm1_on) begin
        if (s.core[i].mod_cnt >= MOD_HALF - 8'h01) begin
          c.mod_cnt = 8'h00;
          c.mod_phase = !s.core[i].mod_phase;
        end else begin
          c.mod_cnt = 8'(s.core[i].mod_cnt + 8'h01);
        end
      end else begin
        c.mod_cnt = 8'h00;
        c.mod_phase = 1'b0;
      end
      next_s.run[i] = !tm1_on || s.core[i].mod_phase;
      // lowest mode only while hot; request resumes after
      next_s.lowest_frequency_mode[i] = tm2_on;
      // two threshold crossings in either direction
      above_now[0] = c.offset <= cfg.thresh0;
      above_now[1] = c.offset <= cfg.thresh1;
      if (c.valid) begin
        c.above = above_now;
      end
      next_s.irq[i] = (c.valid && (above_now != s.core[i].above)) || oos_hit || hot_irq;
      next_s.core[i] = c;
    end
    // one package pin for all cores
    next_s.drive_hot = any_trip;
    // Remember our recent drive until the synchroniser has seen the pin released
    next_s.drive_dly = {s.drive_dly[0], s.drive_hot};
    // sensor seen only through the read port
    next_s.rvalid = msr_rd;
    if (msr_rd) begin
      next_s.rdata.valid = s.core[msr_core].valid;
      next_s.rdata.overtemp_status = s.core[msr_core].overtemp_status;
      next_s.rdata.sticky = s.core[msr_core].sticky;
      next_s.rdata.offset = s.core[msr_core].offset;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s <= '0;
      s.hot_s1 <= 1'b1;
      s.hot_s2 <= 1'b1;
      s.hot_d <= 1'b1;
      s.run <= '1;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Pin level is always low; only the enable moves, as open drain needs
  assign hot_signal_bidir_out = 1'b0;
  // drive the pin while any core is hot
  assign hot_signal_bidir_oe_n = !s.drive_hot;
  // plain flop, no bus or core involvement
  assign catastrophic_trip_n = !s.trip;
  assign core_clk_run = s.run;
  assign core_lfm = s.lowest_frequency_mode;
  assign thermal_irq = s.irq;
  assign msr_rvalid = s.rvalid;
  assign msr_rdata = s.rdata;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence cata_seen_s;
    |cata_vec;
  endsequence

  sequence trip_out_s;
    !catastrophic_trip_n;
  endsequence

  trip_on_heat_a: assert property (@(posedge ref_clk) disable iff (rst) cata_seen_s |=> trip_out_s)
    else $error("trip output missed catastrophic temperature");

  trip_holds_a: assert property (@(posedge ref_clk) disable iff (rst) trip_out_s |=> trip_out_s)
    else $error("trip output released without reset");

  // pin driven whenever a core is tripped
  hot_pin_drive_a: assert property (@(posedge ref_clk) disable iff (rst) (|tripped_vec) |-> !hot_signal_bidir_oe_n)
    else $error("hot pin not driven while a core trips");

  offset_bound_a: assert property (@(posedge ref_clk) disable iff (rst) msr_rvalid |-> msr_rdata.offset <= TJ_MAX)
    else $error("sensor offset beyond maximum junction temperature");

  // external hot with performance throttle drops all cores
  ext_pstate_a: assert property (@(posedge ref_clk) disable iff (rst)
    (cfg.tm2_en && ext_hot) |=> (&core_lfm && &core_clk_run))
    else $error("external hot did not give lowest state only");

  // a cool core keeps running clocks
  cool_core_runs_a: assert property (@(posedge ref_clk) disable iff (rst)
    (!s.core[NCORES-1].tripped && !ext_hot) |=> core_clk_run[NCORES-1])
    else $error("cool core had clocks gated");

  sticky_follow_a: assert property (@(posedge ref_clk) disable iff (rst)
    s.core[0].overtemp_status |-> s.core[0].sticky)
    else $error("overtemp status without sticky bit");

  // assertion edge raises the interrupt one cycle later
  hot_edge_irq_a: assert property (@(posedge ref_clk) disable iff (rst)
    ($fell(s.hot_s2) && cfg.irq_rise) |=> &thermal_irq)
    else $error("hot assertion edge gave no interrupt");

  lowpower_invalid_a: assert property (@(posedge ref_clk) disable iff (rst) !pkg_normal |=> !s.core[0].valid)
    else $error("reading valid outside normal state");

  // gated phase lasts at least eight cycles while modulation runs
  mod_half_a: assert property (@(posedge ref_clk) disable iff (rst)
    ($fell(core_clk_run[NCORES-1]) && cfg.tm1_en && !cfg.tm2_en && s.core[NCORES-1].tripped
     && s.core[NCORES-1].mod_cnt == 8'h01 && s.core[NCORES-1].offset == 8'h00 && pkg_normal)
    |-> !core_clk_run[NCORES-1] [*8])
    else $error("modulation off phase too short");

  // ----------------------------------------
  // Throttle assertions on core zero
  // ----------------------------------------
  sequence pstate_hot_s;
    cfg.tm2_en && s.core[0].tripped;
  endsequence

  sequence pstate_cool_s;
    cfg.tm2_en && !s.core[0].tripped && !ext_hot;
  endsequence

  sequence ext_mod_start_s;
    $rose(ext_hot) && cfg.tm1_en && !cfg.tm2_en && s.core[0].mod_cnt == 8'h00 && !s.core[0].mod_phase;
  endsequence

  // tripped core with performance throttle goes to the lowest state
  pstate_drop_a: assert property (@(posedge ref_clk) disable iff (rst) pstate_hot_s |=> core_lfm[0])
    else $error("hot core missed the lowest state");

  // cooled core leaves the lowest state
  pstate_return_a: assert property (@(posedge ref_clk) disable iff (rst) pstate_cool_s |=> !core_lfm[0])
    else $error("cool core held in the lowest state");

  // external hot with modulation only gates the clock at once
  ext_mod_a: assert property (@(posedge ref_clk) disable iff (rst) ext_mod_start_s |=> !core_clk_run[0])
    else $error("external hot did not start modulation");

endmodule // thermal_protection_control
`default_nettype wire

/* File: verif/hot_monitor_model.sv */
// Regulator monitor model that may pull the shared hot pin low
`default_nettype none
module hot_monitor_model (
  // Clock and bench request
  input wire logic ref_clk,
  input wire logic pull_req,
  // Device side of the open-drain pin
  input wire logic dev_out,
  input wire logic dev_oe_n,
  // Resolved pin level
  output logic pin_level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pulling = 1'b0;
  // backup pull low
  // Request moves just after an edge, so the device never sees a glitch
  always @(posedge ref_clk) begin
    pulling <= pull_req;
  end
  // Pull-up holds the pin high unless some party pulls it low
  assign pin_level = (pulling || (!dev_oe_n && !dev_out)) ? 1'b0 : 1'b1;
endmodule // hot_monitor_model
`default_nettype wire

/* File: verif/thermal_protection_control_test.sv */
// Self-checking bench for the thermal protection control block
`default_nettype none
`include "thermal_protection_regs.svh"
module thermal_protection_control_test import thermal_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] TJ = 8'h64;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0][7:0] core_temp = '{8'h32, 8'h32};
  logic pkg_normal = 1'b1;
  cfg_t cfg = '0;
  logic [1:0] sticky_clr = 2'h0;
  logic msr_rd = 1'b0;
  logic [0:0] msr_core = 1'h0;
  logic pull_req = 1'b0;
  logic msr_rvalid, pin_level, hot_out, hot_oe_n, trip_n;
  logic [1:0] clk_run, lowest_frequency_mode, irq, seen;
  dts_read_t d;
  dts_read_t msr_rdata;
  int n_fail = 0;
  int total_checks = 0;
  int n;
  // Device and far-side monitor
  thermal_protection_control #(.NCORES(2), .TJ_MAX(TJ)) u_thermal_protection_control (.ref_clk(ref_clk),
    .rst(rst), .core_temp(core_temp), .pkg_normal(pkg_normal), .cfg(cfg), .sticky_clr(sticky_clr),
    .msr_rd(msr_rd), .msr_core(msr_core), .msr_rvalid(msr_rvalid), .msr_rdata(msr_rdata),
    .hot_signal_bidir_in(pin_level), .hot_signal_bidir_out(hot_out), .hot_signal_bidir_oe_n(hot_oe_n),
    .catastrophic_trip_n(trip_n), .core_clk_run(clk_run), .core_lfm(lowest_frequency_mode), .thermal_irq(irq));
  hot_monitor_model u_hot_monitor_model (.ref_clk(ref_clk), .pull_req(pull_req), .dev_out(hot_out),
    .dev_oe_n(hot_oe_n), .pin_level(pin_level));
  // 25 ns clock
  always #12.5 ref_clk = ~ref_clk;
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // Sample just after the edge so the edge's updates have landed
  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  task automatic rd(input logic k);
    @(posedge ref_clk);
    msr_rd <= 1'b1;
    msr_core <= k;
    @(posedge ref_clk);
    msr_rd <= 1'b0;
    #1;
    chk(msr_rvalid, 1'b1, "rvalid");
    d = msr_rdata;
  endtask
  task automatic set_cfg(input logic t1, input logic t2, input logic f, input logic ir, input logic fa);
    @(posedge ref_clk);
    cfg <= '{t1, t2, f, ir, fa, 8'h0a, 8'h05};
  endtask
  task automatic heat(input logic [7:0] t0, input logic [7:0] t1);
    @(posedge ref_clk);
    core_temp <= '{t1, t0};
    cyc(4);
  endtask
  task automatic watch_irq(input int k);
    seen = 2'b00;
    repeat (k) begin
      cyc(1);
      seen |= irq;
    end
  endtask
  // Run a duty phase and count its length, bounded
  task automatic phase(input logic lvl);
    n = 0;
    while (clk_run[1] === lvl && n < 100) begin
      cyc(1);
      n++;
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_read();
    chk({trip_n, hot_oe_n, hot_out, clk_run, lowest_frequency_mode, irq, msr_rvalid}, 10'h360, "reset outputs");
    set_cfg(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    rd(1'b0);
    chk({d.valid, d.offset}, 9'h132, "offset below max");
    @(posedge ref_clk);
    core_temp <= '{8'h32, TJ - 8'h05};
    watch_irq(8);
    chk(seen, 2'b01, "threshold irq");
    pkg_normal <= 1'b0;
    cyc(3);
    rd(1'b0);
    chk(d.valid, 1'b0, "low power reading");
    pkg_normal <= 1'b1;
    heat(8'h32, 8'h32);
    $display("t_read done");
  endtask
  task automatic t_pstate();
    set_cfg(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    heat(TJ, 8'h32);
    chk(hot_oe_n, 1'b0, "hot pin driven");
    chk({lowest_frequency_mode, clk_run}, 4'h7, "lowest state hot core");
    cyc(`OOS_CYC);
    rd(1'b0);
    chk({d.overtemp_status, d.sticky, d.offset}, 10'h300, "overtemp latched");
    heat(TJ - 8'h02, 8'h32);
    chk({lowest_frequency_mode, hot_oe_n}, 3'h1, "back to request");
    rd(1'b0);
    chk({d.overtemp_status, d.sticky}, 2'b01, "sticky kept");
    sticky_clr <= 2'b01;
    @(posedge ref_clk);
    sticky_clr <= 2'b00;
    rd(1'b0);
    chk(d.sticky, 1'b0, "sticky cleared");
    $display("t_pstate done");
  endtask
  task automatic t_mod();
    set_cfg(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    @(posedge ref_clk);
    core_temp <= '{TJ + 8'h03, 8'h32};
    phase(1'b1);
    chk(clk_run, 2'b01, "only hot core gated");
    phase(1'b0);
    chk(n, `MOD_HALF_CYC, "off half");
    phase(1'b1);
    chk(n, `MOD_HALF_CYC, "on half");
    rd(1'b1);
    chk(d.offset, 8'h00, "offset capped");
    heat(8'h32, TJ - 8'h02);
    cyc(2 * `MOD_HALF_CYC);
    chk(clk_run, 2'b11, "modulation ends");
    $display("t_mod done");
  endtask
  task automatic t_ext();
    set_cfg(1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
    @(posedge ref_clk);
    pull_req <= 1'b1;
    watch_irq(8);
    chk(seen, 2'b11, "irq on assert");
    seen = 2'b11;
    repeat (30) begin
      cyc(1);
      seen &= clk_run;
    end
    chk({lowest_frequency_mode, seen}, 4'hf, "lowest state only");
    pull_req <= 1'b0;
    watch_irq(8);
    chk({seen, lowest_frequency_mode}, 4'h0, "no irq on release");
    set_cfg(1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
    pull_req <= 1'b1;
    phase(1'b1);
    chk({clk_run, lowest_frequency_mode}, 4'h0, "external modulation");
    pull_req <= 1'b0;
    watch_irq(8);
    chk(seen, 2'b11, "irq on release");
    cyc(2 * `MOD_HALF_CYC);
    $display("t_ext done");
  endtask
  task automatic t_trip();
    set_cfg(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    pkg_normal <= 1'b0;
    heat(8'h32, `CATA_TEMP);
    chk({trip_n, msr_rvalid}, 2'b00, "trip without bus");
    pkg_normal <= 1'b1;
    heat(8'h32, 8'h32);
    chk(trip_n, 1'b0, "trip held");
    rst <= 1'b1;
    cyc(2);
    rst <= 1'b0;
    cyc(1);
    chk(trip_n, 1'b1, "trip cleared by reset");
    $display("t_trip done");
  endtask
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    cyc(1);
    t_read();
    t_pstate();
    t_mod();
    t_ext();
    t_trip();
    stop_test();
  end
  // Watchdog, well beyond the roughly 660 cycles the tests need
  initial begin
    repeat (5000) @(posedge ref_clk);
    n_fail++;
    $display("Error at %0t: watchdog expired", $time);
    stop_test();
  end
endmodule // thermal_protection_control_test
`default_nettype wire
